// [verilog/epd_pkg.sv]
// epd_pkg: constants, register map and types of the eight-channel peripheral dma
// assumes a single clock domain and a word-addressed internal ram of 48k words
package epd_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NCH       = 8;
	localparam int NIDX      = 4;
	localparam int NSRC      = 4;
	localparam int MAX_SLOTS = 128;

	// ----------------------------------------------------------------
	// peripheral source select codes
	// ----------------------------------------------------------------
	localparam logic [1:0] SRC_EXT = 2'h0;
	localparam logic [1:0] SRC_SP0 = 2'h1;
	localparam logic [1:0] SRC_SP1 = 2'h2;
	localparam logic [1:0] SRC_HPP = 2'h3;

	// ----------------------------------------------------------------
	// register map (byte addresses); channel block n sits at n * 0x20
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_BASE = 12'h000;
	localparam logic [11:0] OFF_BLEN = 12'h004;
	localparam logic [11:0] OFF_NBUF = 12'h008;
	localparam logic [11:0] OFF_CTRL = 12'h00c;
	localparam logic [11:0] OFF_PTR  = 12'h010;
	localparam logic [11:0] OFF_STAT = 12'h100;
	localparam logic [11:0] OFF_CLR  = 12'h104;
	localparam logic [11:0] OFF_IEN  = 12'h108;
	localparam int          CH_SHIFT = 5;

	// control register bit positions
	localparam int CTL_EN    = 0;
	localparam int CTL_CONT  = 1;
	localparam int CTL_DIR   = 2;
	localparam int CTL_SRC   = 3;
	localparam int CTL_IDX   = 5;
	localparam int CTL_BYTE8 = 6;
	localparam int CTL_RUN   = 8;

	// values after reset
	localparam logic [15:0] RST_BASE = 16'h0000;
	localparam logic [15:0] RST_BLEN = 16'h0001;
	localparam logic [7:0]  RST_NBUF = 8'h01;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] base;
		logic [15:0] blen;
		logic [7:0]  nbuf;
		logic        en;
		logic        cont;
		logic        dir;
		logic [1:0]  src;
		logic        idx;
		logic        byte8;
	} epd_cfg_type;

	typedef struct packed {
		logic        run;
		logic        pend;
		logic        half;
		logic [7:0]  slot;
		logic [15:0] cnt;
		logic [15:0] hold;
	} epd_run_type;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} epd_mem_type;

	typedef enum logic [1:0] {
		EPD_IDLE   = 2'b00,
		EPD_RDWAIT = 2'b01,
		EPD_RDDATA = 2'b11
	} epd_eng_type;

	typedef struct packed {
		epd_cfg_type [NCH-1:0] prog;
		epd_cfg_type [NCH-1:0] act;
		epd_run_type [NCH-1:0] chn;
		epd_eng_type           eng;
		logic [2:0]            sel;
		logic [NCH-1:0]        stat;
		logic [NCH-1:0]        ien;
		logic                  irq;
		logic                  pready;
		logic                  pslverr;
		logic [31:0]           prdata;
		epd_mem_type           mem;
		logic [15:0]           pwdata;
		logic [NSRC-1:0]       pwvalid;
	} epd_state_type;

endpackage

// [verilog/epd_dma.sv]
// epd_dma: eight-channel peripheral dma with apb registers and one interrupt
// assumes a ram that takes a request in one cycle and returns read data the next,
// and peripherals that pulse their request one cycle with data already valid
//
// The APB register port and the placing of the registers are this design's own decisions.
module epd_dma
(
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rstn,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic                               pready,
	output logic                               pslverr,
	output logic [31:0]                        prdata,
	// interrupt
	output logic                               irq,
	// internal ram port
	output epd_pkg::epd_mem_type               mem_o,
	input  wire logic [15:0]                   mem_rdata,
	// peripherals: 0 ext memory, 1 serial 0, 2 serial 1, 3 host parallel port
	input  wire logic [epd_pkg::NSRC-1:0]      periph_req,
	input  wire logic [epd_pkg::NSRC-1:0][15:0] periph_rdata,
	output logic [15:0]                        periph_wdata,
	output logic [epd_pkg::NSRC-1:0]           periph_wvalid
);
	import epd_pkg::*;

	epd_state_type q;
	epd_state_type d;

	// ----------------------------------------------------------------
	// address and stepping helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] cur_addr(epd_cfg_type c, epd_run_type r, logic indexed);
		logic [23:0] off;
		off = (indexed && c.idx) ? 24'(r.slot * c.blen) : 24'h00_0000;
		return 16'(c.base + off[15:0] + r.cnt);
	endfunction

	function automatic logic at_end(epd_cfg_type c, epd_run_type r, logic indexed);
		logic [23:0] tot;
		tot = 24'(c.blen * c.nbuf);
		if (!indexed)
			return r.cnt == 16'(c.blen - 16'h0001);
		else if (!c.idx)
			return {8'h00, r.cnt} == 24'(tot - 24'h00_0001);
		else
			return (r.slot == 8'(c.nbuf - 8'h01)) && (r.cnt == 16'(c.blen - 16'h0001));
	endfunction

	function automatic epd_run_type step(epd_cfg_type c, epd_run_type r, logic indexed);
		epd_run_type n;
		n = r;
		if (indexed && c.idx)
		begin
			if (r.slot == 8'(c.nbuf - 8'h01))
			begin
				// whole frame served: move to the next word of every slot buffer
				n.slot = 8'h00;
				n.cnt  = 16'(r.cnt + 16'h0001);
			end
			else
			begin
				n.slot = 8'(r.slot + 8'h01);
			end
		end
		else
		begin
			n.cnt = 16'(r.cnt + 16'h0001);
		end
		return n;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic        found;
		logic [2:0]  s;
		logic [2:0]  rch;
		logic [2:0]  wch;
		logic        wadv;
		logic        wdone;
		epd_cfg_type c;
		epd_run_type nr;
		found = 1'b0;
		nr    = '0;
		s     = 3'h0;
		rch   = paddr[CH_SHIFT+2:CH_SHIFT];
		wch   = 3'h0;
		wadv  = 1'b0;
		wdone = 1'b0;
		c     = '0;
		d     = q;

		d.mem.req  = 1'b0;
		d.mem.we   = 1'b0;
		d.pwvalid  = '0;
		d.pready   = psel && !penable;
		d.pslverr  = 1'b0;

		// software clear first, so a completion in the same cycle still sets
		if (psel && penable && q.pready && pwrite && paddr == OFF_CLR)
			d.stat = q.stat & ~pwdata[NCH-1:0];

		// ------------------------------------------------------------
		// engine: one ram access at a time, lowest channel first
		// ------------------------------------------------------------
		case (q.eng)
			EPD_IDLE:
			begin
				for (int i = NCH - 1; i >= 0; i--)
				begin
					if (q.chn[i].run && q.chn[i].pend)
					begin
						found = 1'b1;
						s     = 3'(i);
					end
				end
				if (found)
				begin
					c = q.act[s];
					d.chn[s].pend = 1'b0;
					if (!c.dir)
					begin
						if (c.src == SRC_HPP && !q.chn[s].half)
						begin
							d.chn[s].half = 1'b1;
						end
						else
						begin
							d.mem.req   = 1'b1;
							d.mem.we    = 1'b1;
							d.mem.addr  = cur_addr(c, q.chn[s], s < 3'(NIDX));
							d.mem.wdata = c.byte8 ? {8'h00, q.chn[s].hold[7:0]} : q.chn[s].hold;
							d.chn[s].half = 1'b0;
							wch  = s;
							wadv = 1'b1;
						end
					end
					else if (c.src == SRC_HPP && q.chn[s].half)
					begin
						// second byte of a word already fetched: no ram access
						d.pwdata         = {8'h00, q.chn[s].hold[15:8]};
						d.pwvalid[c.src] = 1'b1;
						d.chn[s].half    = 1'b0;
						wch  = s;
						wadv = 1'b1;
					end
					else
					begin
						d.mem.req  = 1'b1;
						d.mem.addr = cur_addr(c, q.chn[s], s < 3'(NIDX));
						d.sel      = s;
						d.eng      = EPD_RDWAIT;
					end
				end
			end
			EPD_RDWAIT:
			begin
				// the ram answers one cycle after it sees the request
				d.eng = EPD_RDDATA;
			end
			EPD_RDDATA:
			begin
				s = q.sel;
				c = q.act[s];
				if (c.src == SRC_HPP)
				begin
					// pointer moves only once the high byte has gone out
					d.pwdata      = {8'h00, mem_rdata[7:0]};
					d.chn[s].hold = mem_rdata;
					d.chn[s].half = 1'b1;
				end
				else
				begin
					d.pwdata = c.byte8 ? {8'h00, mem_rdata[7:0]} : mem_rdata;
					wch  = s;
					wadv = 1'b1;
				end
				d.pwvalid[c.src] = 1'b1;
				d.eng = EPD_IDLE;
			end
			default:
			begin
				d.eng = EPD_IDLE;
			end
		endcase

		// ------------------------------------------------------------
		// pointer advance, completion and continuous restart
		// ------------------------------------------------------------
		if (wadv)
		begin
			c     = q.act[wch];
			wdone = at_end(c, q.chn[wch], wch < 3'(NIDX));
			nr    = step(c, q.chn[wch], wch < 3'(NIDX));
			d.chn[wch].cnt  = nr.cnt;
			d.chn[wch].slot = nr.slot;
			if (wdone)
			begin
				d.stat[wch] = 1'b1;
				if (c.cont && q.prog[wch].en)
				begin
					// restart picks up whatever software has queued meanwhile
					d.act[wch]      = q.prog[wch];
					d.chn[wch].cnt  = 16'h0000;
					d.chn[wch].slot = 8'h00;
					d.chn[wch].half = 1'b0;
					d.chn[wch].pend = 1'b0;
				end
				else
				begin
					d.chn[wch].run  = 1'b0;
					d.chn[wch].pend = 1'b0;
					d.prog[wch].en  = 1'b0;
				end
			end
		end

		// ------------------------------------------------------------
		// request capture and channel start
		// ------------------------------------------------------------
		for (int i = 0; i < NCH; i++)
		begin
			// a request while one is still pending is an overrun and is dropped
			if (q.chn[i].run && !q.chn[i].pend && periph_req[q.act[i].src])
			begin
				d.chn[i].pend = 1'b1;
				if (!q.act[i].dir)
				begin
					if (q.act[i].src == SRC_HPP && q.chn[i].half)
						d.chn[i].hold[15:8] = periph_rdata[q.act[i].src][7:0];
					else if (q.act[i].src == SRC_HPP)
						d.chn[i].hold[7:0] = periph_rdata[q.act[i].src][7:0];
					else
						d.chn[i].hold = periph_rdata[q.act[i].src];
				end
			end
			if (!q.chn[i].run && q.prog[i].en)
			begin
				// settings are copied once; later writes wait for the next start
				d.act[i]      = q.prog[i];
				d.chn[i].run  = 1'b1;
				d.chn[i].pend = 1'b0;
				d.chn[i].half = 1'b0;
				d.chn[i].cnt  = 16'h0000;
				d.chn[i].slot = 8'h00;
			end
		end

		// ------------------------------------------------------------
		// apb: decode in setup, data ready in access
		// ------------------------------------------------------------
		if (psel && !penable)
		begin
			d.prdata = 32'h0000_0000;
			if (paddr[1:0] != 2'b00)
				d.pslverr = 1'b1;
			else if (paddr == OFF_STAT)
				d.prdata = {24'h00_0000, q.stat};
			else if (paddr == OFF_IEN)
				d.prdata = {24'h00_0000, q.ien};
			else if (paddr == OFF_CLR)
				d.pslverr = !pwrite;
			else if (paddr[11:8] != 4'h0)
				d.pslverr = 1'b1;
			else
			begin
				case ({7'h00, paddr[CH_SHIFT-1:0]})
					OFF_BASE: d.prdata = {16'h0000, q.prog[rch].base};
					OFF_BLEN: d.prdata = {16'h0000, q.prog[rch].blen};
					OFF_NBUF: d.prdata = {24'h00_0000, q.prog[rch].nbuf};
					OFF_CTRL: d.prdata = {23'h00_0000, q.chn[rch].run, 1'b0, q.prog[rch].byte8,
						q.prog[rch].idx, q.prog[rch].src, q.prog[rch].dir,
						q.prog[rch].cont, q.prog[rch].en};
					OFF_PTR:  d.prdata = {16'h0000,
						cur_addr(q.act[rch], q.chn[rch], rch < 3'(NIDX))};
					default:  d.pslverr = 1'b1;
				endcase
			end
		end

		if (psel && penable && q.pready && pwrite && !q.pslverr)
		begin
			if (paddr == OFF_IEN)
				d.ien = pwdata[NCH-1:0];
			else if (paddr[11:8] == 4'h0)
			begin
				case ({7'h00, paddr[CH_SHIFT-1:0]})
					OFF_BASE: d.prog[rch].base = pwdata[15:0];
					OFF_BLEN: d.prog[rch].blen = pwdata[15:0];
					OFF_NBUF: d.prog[rch].nbuf = pwdata[7:0];
					OFF_CTRL:
					begin
						d.prog[rch].en    = pwdata[CTL_EN];
						d.prog[rch].cont  = pwdata[CTL_CONT];
						d.prog[rch].dir   = pwdata[CTL_DIR];
						d.prog[rch].src   = pwdata[CTL_SRC+1:CTL_SRC];
						// slot indexing exists on the first four channels only
						d.prog[rch].idx   = pwdata[CTL_IDX] && (rch < 3'(NIDX));
						d.prog[rch].byte8 = pwdata[CTL_BYTE8];
					end
					default:
					begin
						d.prog[rch].en = d.prog[rch].en;
					end
				endcase
			end
		end

		d.irq = |(d.stat & d.ien);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			q <= '0;
			for (int i = 0; i < NCH; i++)
			begin
				q.prog[i].base <= RST_BASE;
				q.prog[i].blen <= RST_BLEN;
				q.prog[i].nbuf <= RST_NBUF;
				q.act[i].blen  <= RST_BLEN;
				q.act[i].nbuf  <= RST_NBUF;
			end
		end
		else
		begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign pready        = q.pready;
	assign pslverr       = q.pslverr;
	assign prdata        = q.prdata;
	assign irq           = q.irq;
	assign mem_o         = q.mem;
	assign periph_wdata  = q.pwdata;
	assign periph_wvalid = q.pwvalid;

endmodule

// [verification/epd_dma_monitor.sv]
// epd_mon: port assertions for the eight-channel dma
// assumes bind to epd_dma; one clock, async active-low reset
module epd_mon
(
	// clock and reset
	input wire logic                     clk,
	input wire logic                     rstn,
	// apb
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic [11:0]              paddr,
	input wire logic                     pready,
	input wire logic                     pslverr,
	// ram and peripherals
	input wire epd_pkg::epd_mem_type     mem_o,
	input wire logic [epd_pkg::NSRC-1:0] periph_wvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	import epd_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// ----
	// sequences
	// ----
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_rd;
		mem_o.req && !mem_o.we;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
		else $error("misaligned access accepted");
	a_ram_range: assert property (mem_o.req |-> mem_o.addr < 16'hc000)
		else $error("ram address out of range");
	a_read_spacing: assert property (s_rd |=> !mem_o.req)
		else $error("second ram access in flight");
	a_out_onehot: assert property ($onehot0(periph_wvalid))
		else $error("two peripheral strobes");
	a_tx_after_read: assert property (periph_wvalid[2:0] != 3'h0 |-> $past(mem_o.req && !mem_o.we, 2))
		else $error("peripheral strobe without ram read");
endmodule

// [verification/epd_peer.sv]
// epd_peer: behavioural internal ram behind the dma memory port
// assumes read data is wanted one cycle after a read request
module epd_peer
(
	// clock
	input wire logic                 clk,
	// memory port
	input wire epd_pkg::epd_mem_type mem_o,
	output logic [15:0]              mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	import epd_pkg::*;
	logic [15:0] ram [0:65535];
	initial mem_rdata = 16'h5a5a;
	always @(posedge clk)
	begin
		if (mem_o.req && mem_o.we)
			ram[mem_o.addr] <= mem_o.wdata;
		// toggle outside the read slot so stale data is never reused
		if (mem_o.req && !mem_o.we)
			mem_rdata <= ram[mem_o.addr];
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule

// [verification/test_eight_channel_peripheral_dma.sv]
// test_eight_channel_peripheral_dma: directed bench, apb master and requests
// assumes epd_peer as ram; peripherals are driven here as one-cycle pulses
module test_eight_channel_peripheral_dma;
	timeunit 1ns;
	timeprecision 1ns;
	import epd_pkg::*;
	logic                      clk;
	logic                      rstn;
	logic                      psel;
	logic                      penable;
	logic                      pwrite;
	logic [11:0]               paddr;
	logic [31:0]               pwdata;
	logic                      pready;
	logic                      pslverr;
	logic [31:0]               prdata;
	logic                      irq;
	epd_mem_type               mem_o;
	logic [15:0]               mem_rdata;
	logic [NSRC-1:0]           periph_req;
	logic [NSRC-1:0][15:0]     periph_rdata;
	logic [15:0]               periph_wdata;
	logic [NSRC-1:0]           periph_wvalid;
	int                        fails = 0;
	int                        tests_run = 0;
	epd_dma i_epd_dma (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .irq(irq), .mem_o(mem_o),
		.mem_rdata(mem_rdata), .periph_req(periph_req), .periph_rdata(periph_rdata),
		.periph_wdata(periph_wdata), .periph_wvalid(periph_wvalid));
	epd_peer i_epd_peer (.clk(clk), .mem_o(mem_o), .mem_rdata(mem_rdata));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----
	// helpers
	// ----
	task automatic tally_and_finish;
		$display("fails %0d tests_run %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20)
		begin
			fails++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		check(q, x);
	endtask
	task automatic er(input logic [11:0] a);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		check(32'(e), 32'h0000_0001);
	endtask
	function automatic logic [11:0] ca(input int c, input logic [11:0] o);
		return 12'(c << CH_SHIFT) | o;
	endfunction
	task automatic cfg(input int c, input logic [15:0] b, input logic [15:0] l,
		input logic [7:0] n, input logic [31:0] k);
		wr(ca(c, OFF_BASE), 32'(b));
		wr(ca(c, OFF_BLEN), 32'(l));
		wr(ca(c, OFF_NBUF), 32'(n));
		wr(ca(c, OFF_CTRL), k);
		repeat (2) @(posedge clk);
	endtask
	task automatic prq(input int s, input logic [15:0] d);
		@(posedge clk);
		periph_req[s] <= 1'b1;
		periph_rdata[s] <= d;
		@(posedge clk);
		periph_req[s] <= 1'b0;
		periph_rdata[s] <= ~d;
	endtask
	task automatic rx(input int s, input logic [15:0] d);
		prq(s, d);
		repeat (4) @(posedge clk);
	endtask
	task automatic tx(input int s, input logic [15:0] x);
		int n;
		prq(s, 16'h0000);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (periph_wvalid[s] !== 1'b1 && n < 8);
		if (n == 8)
		begin
			fails++;
			tally_and_finish();
		end
		check(32'(periph_wdata), 32'(x));
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset;
		rd(ca(4, OFF_BASE), 32'(RST_BASE));
		rd(ca(4, OFF_BLEN), 32'(RST_BLEN));
		rd(ca(7, OFF_NBUF), 32'(RST_NBUF));
		rd(OFF_STAT, 32'h0000_0000);
		er(12'h200);
		er(12'h002);
		er(OFF_CLR);
	endtask
	task automatic t_rx;
		wr(OFF_IEN, 32'h0000_0010);
		cfg(4, 16'h0100, 16'h0003, 8'h01, 32'h0000_0009);
		for (int i = 0; i < 3; i++)
			rx(1, 16'(16'h1111 * (i + 1)));
		for (int i = 0; i < 3; i++)
			check(32'(i_epd_peer.ram[16'h0100 + i]), 32'(16'h1111 * (i + 1)));
		rd(OFF_STAT, 32'h0000_0010);
		check(32'(irq), 32'h0000_0001);
		rd(ca(4, OFF_CTRL), 32'h0000_0008);
	endtask
	task automatic t_tx;
		cfg(5, 16'h0100, 16'h0002, 8'h01, 32'h0000_0015);
		tx(2, 16'h1111);
		tx(2, 16'h2222);
		repeat (4) @(posedge clk);
		rd(OFF_STAT, 32'h0000_0030);
		wr(OFF_CLR, 32'h0000_0010);
		repeat (2) @(posedge clk);
		check(32'(irq), 32'h0000_0000);
		rd(OFF_STAT, 32'h0000_0020);
		wr(OFF_CLR, 32'h0000_0020);
	endtask
	task automatic t_host;
		cfg(6, 16'h0200, 16'h0001, 8'h01, 32'h0000_0019);
		rx(3, 16'hff34);
		rx(3, 16'hff12);
		check(32'(i_epd_peer.ram[16'h0200]), 32'h0000_1234);
		rd(OFF_STAT, 32'h0000_0040);
		wr(OFF_CLR, 32'h0000_0040);
		cfg(6, 16'h0200, 16'h0001, 8'h01, 32'h0000_001d);
		tx(3, 16'h0034);
		tx(3, 16'h0012);
		repeat (2) @(posedge clk);
		rd(OFF_STAT, 32'h0000_0040);
		wr(OFF_CLR, 32'h0000_0040);
	endtask
	task automatic t_index;
		cfg(0, 16'h0300, 16'h0002, 8'h02, 32'h0000_0031);
		for (int i = 0; i < 4; i++)
			rx(2, 16'(16'h00a0 + i));
		for (int i = 0; i < 4; i++)
			check(32'(i_epd_peer.ram[16'h0300 + (i % 2) * 2 + i / 2]), 32'(16'h00a0 + i));
		rd(OFF_STAT, 32'h0000_0001);
		wr(OFF_CLR, 32'h0000_0001);
	endtask
	task automatic t_cont;
		cfg(7, 16'h0500, 16'h0001, 8'h01, 32'h0000_0003);
		wr(ca(7, OFF_BASE), 32'h0000_0600);
		rx(0, 16'h7777);
		check(32'(i_epd_peer.ram[16'h0500]), 32'h0000_7777);
		rx(0, 16'h8888);
		check(32'(i_epd_peer.ram[16'h0600]), 32'h0000_8888);
		rd(OFF_STAT, 32'h0000_0080);
		wr(ca(7, OFF_CTRL), 32'h0000_0000);
		repeat (2) @(posedge clk);
		rx(0, 16'h9999);
		check(32'(i_epd_peer.ram[16'h0600]), 32'h0000_9999);
		rd(ca(7, OFF_CTRL), 32'h0000_0000);
		rx(0, 16'haaaa);
		check(32'(i_epd_peer.ram[16'h0600]), 32'h0000_9999);
	endtask
	initial
	begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		periph_req = 4'h0;
		periph_rdata = '0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_rx();
		t_tx();
		t_host();
		t_index();
		t_cont();
		tally_and_finish();
	end
endmodule
bind epd_dma epd_mon i_epd_mon (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .mem_o(mem_o),
	.periph_wvalid(periph_wvalid));
